/* File: include/dacuc_pkg.sv */
// Purpose: shared constants for the converter update control block
// Assumes: apb with 32-bit data, one register per aligned word
// Notes: offsets are byte addresses
package dacuc_pkg;
    localparam logic [11:0] OFF_CONTROL = 12'h000;
    localparam logic [11:0] OFF_VALUE_LOW = 12'h004;
    localparam logic [11:0] OFF_VALUE_HIGH = 12'h008;
    localparam logic [11:0] OFF_STATUS = 12'h00c;
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [7:0] RST_VALUE = 8'h00;
    localparam logic [9:0] RST_SHADOW = 10'h000;
    localparam int CTL_AUTO_TRIG = 7;
    localparam int CTL_TSEL_LO = 4;
    localparam int CTL_TSEL_HI = 6;
    localparam int CTL_LEFT_ALIGN = 2;
    localparam int CTL_PIN_OE = 1;
    localparam int CTL_ENABLE = 0;
    localparam logic [7:0] CTL_WMASK = 8'hf7;
    // conversion settling time after a shadow load
    localparam int CONV_TIME_NS = 1000;
    localparam int CLK_PERIOD_NS = 50;
    localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
    localparam logic [7:0] CONV_CYCLES_W = 8'(CONV_CYCLES);
    typedef enum logic [2:0] {
        DACUC_IDLE = 3'b001,
        DACUC_ARMED = 3'b010,
        DACUC_BUSY = 3'b100
    } dacuc_state_t;
endpackage : dacuc_pkg

/* File: rtl/dacuc_sync.sv */
// Purpose: three-stage synchroniser with agreement filter for one flag
// Assumes: flag may come from another clock domain
// Notes: output changes only when stages two and three agree
`timescale 1ns/10ps
module dacuc_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic flag_in,
    output logic flag_out
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic out_q;
    wire agree = (s2_q == s3_q);

    // first stage feeds only the second stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            out_q <= 1'b0;
        end else begin
            s1_q <= flag_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (agree) begin
                out_q <= s3_q;
            end
        end
    end
    assign flag_out = out_q;
endmodule : dacuc_sync

/* File: rtl/dacuc_top.sv */
// Purpose: digital update control of a 10-bit converter behind apb
// Assumes: trigger flags are raw interrupt flags from other blocks
// Notes: shadow value feeds the analog core; one wait-free apb answer
// Contract
// - auto-trigger bit 7 set: load shadow on rising edge of chosen trigger
// - auto-trigger clear: each high register write refreshes the shadow
// - trigger select bits 6:4 choose one of eight flag sources
// - trigger is flag rising edge, interrupt enable ignored; select only in auto
// - control bit 2 set means left-adjusted data, clear right-adjusted
// - alignment change reaches the output only at next high write
// - right: high 1:0 = bits 9:8, low = 7:0; left: high 9:2, low 7:6
// - control bit 1 routes result to analog output pin
// - control bit 0 enables the converter
// - output comes only from hidden shadow, loaded whole
// - low write blocks shadow update until high is written
// - auto mode: update after low then high; high-only updates every trigger; the code drops an edge that meets a high write
// - trigger edge during a conversion is ignored
`timescale 1ns/10ps
module dacuc_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] trigger_flags,
    output logic [9:0] shadow_value,
    output logic converter_enable,
    output logic analog_pin_output_enable,
    output logic conversion_busy
);
    logic [7:0] control_q;
    logic [7:0] value_low_q;
    logic [7:0] value_high_q;
    logic [9:0] shadow_q;
    logic [9:0] shadow_d;
    logic align_q;
    logic low_pending_q;
    logic flag_prev_q;
    logic [7:0] conv_cnt_q;
    logic [7:0] flags_sync;
    dacuc_pkg::dacuc_state_t state_q;
    dacuc_pkg::dacuc_state_t state_d;

    // one synchroniser per trigger source
    genvar gi;
    for (gi = 0; gi < 8; gi++) begin : g_sync
        dacuc_sync u_sync (
            .pclk(pclk),
            .presetn(presetn),
            .flag_in(trigger_flags[gi]),
            .flag_out(flags_sync[gi])
        );
    end

    // apb decode
    wire access = psel && penable;
    wire wr = access && pwrite;
    wire hit_ctl = (paddr == dacuc_pkg::OFF_CONTROL);
    wire hit_low = (paddr == dacuc_pkg::OFF_VALUE_LOW);
    wire hit_high = (paddr == dacuc_pkg::OFF_VALUE_HIGH);
    wire hit_stat = (paddr == dacuc_pkg::OFF_STATUS);
    wire mapped = hit_ctl || hit_low || hit_high || hit_stat;
    wire wr_ctl = wr && hit_ctl;
    wire wr_low = wr && hit_low;
    wire wr_high = wr && hit_high;
    assign pready = 1'b1;
    assign pslverr = access && !mapped;

    // control fields
    wire auto_trigger_enable = control_q[dacuc_pkg::CTL_AUTO_TRIG];
    wire [2:0] trigger_select =
        control_q[dacuc_pkg::CTL_TSEL_HI:dacuc_pkg::CTL_TSEL_LO];
    wire left_align = control_q[dacuc_pkg::CTL_LEFT_ALIGN];

    // raw flag, enable state not looked at
    wire sel_flag = flags_sync[trigger_select];
    wire trig_edge = sel_flag && !flag_prev_q;

    // assemble the 10-bit value from the registers under the latched align
    wire [9:0] value_right = {value_high_q[1:0], value_low_q};
    wire [9:0] value_left = {value_high_q, value_low_q[7:6]};
    wire [9:0] value_sel = align_q ? value_left : value_right;

    // latest high write data combined with stored low byte
    wire [7:0] wh = pwdata[7:0];
    wire [9:0] wr_right = {wh[1:0], value_low_q};
    wire [9:0] wr_left = {wh, value_low_q[7:6]};
    wire [9:0] wr_value = left_align ? wr_left : wr_right;

    // write mode: high write loads shadow at once
    wire load_write = wr_high && !auto_trigger_enable;
    // auto mode: trigger loads when no low write is waiting for high
    wire trig_ok = auto_trigger_enable && trig_edge
                   && (state_q != dacuc_pkg::DACUC_BUSY)
                   && !low_pending_q;
    wire load_trig = trig_ok && !wr_high;

    // shadow next value; loaded as one word, never byte by byte
    always_comb begin
        shadow_d = shadow_q;
        if (load_write) begin
            shadow_d = wr_value;
        end else if (load_trig) begin
            shadow_d = value_sel;
        end
    end

    // conversion tracking fsm
    always_comb begin
        state_d = state_q;
        case (state_q)
            dacuc_pkg::DACUC_IDLE: begin
                if (load_write || load_trig) begin
                    state_d = dacuc_pkg::DACUC_BUSY;
                end
            end
            dacuc_pkg::DACUC_ARMED: begin
                state_d = dacuc_pkg::DACUC_IDLE;
            end
            dacuc_pkg::DACUC_BUSY: begin
                // a write-mode reload on the last cycle keeps the window open
                if (conv_cnt_q == 8'h01 && !load_write) begin
                    state_d = dacuc_pkg::DACUC_IDLE;
                end
            end
            default: begin
                state_d = dacuc_pkg::DACUC_IDLE;
            end
        endcase
    end

    // register file writes; reserved bit 3 stays zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_q <= dacuc_pkg::RST_CONTROL;
            value_low_q <= dacuc_pkg::RST_VALUE;
            value_high_q <= dacuc_pkg::RST_VALUE;
        end else begin
            if (wr_ctl) begin
                control_q <= pwdata[7:0] & dacuc_pkg::CTL_WMASK;
            end
            if (wr_low) begin
                value_low_q <= pwdata[7:0];
            end
            if (wr_high) begin
                value_high_q <= pwdata[7:0];
            end
        end
    end

    // align is latched only by high writes so a flip waits for one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            align_q <= 1'b0;
        end else if (wr_high) begin
            align_q <= left_align;
        end
    end

    // low write arms a block that the high write releases
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_pending_q <= 1'b0;
        end else if (wr_high) begin
            low_pending_q <= 1'b0;
        end else if (wr_low) begin
            low_pending_q <= 1'b1;
        end
    end

    // previous flag sample for edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_prev_q <= 1'b0;
        end else begin
            flag_prev_q <= sel_flag;
        end
    end

    // shadow, state and conversion counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shadow_q <= dacuc_pkg::RST_SHADOW;
            state_q <= dacuc_pkg::DACUC_IDLE;
            conv_cnt_q <= 8'h00;
        end else begin
            shadow_q <= shadow_d;
            state_q <= state_d;
            if (load_write || load_trig) begin
                conv_cnt_q <= dacuc_pkg::CONV_CYCLES_W;
            end else if (conv_cnt_q != 8'h00) begin
                conv_cnt_q <= conv_cnt_q - 8'h01;
            end
        end
    end

    // read mux; high/low read back as stored
    wire [7:0] status_byte = {5'h00, low_pending_q, align_q,
                              state_q == dacuc_pkg::DACUC_BUSY};
    wire [7:0] rd_byte = hit_ctl ? control_q :
                         hit_low ? value_low_q :
                         hit_high ? value_high_q :
                         hit_stat ? status_byte : 8'h00;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= {24'h000000, rd_byte}; // captured in setup phase
        end
    end

    // outputs to the analog core
    assign shadow_value = shadow_q;
    assign converter_enable = control_q[dacuc_pkg::CTL_ENABLE];
    assign analog_pin_output_enable =
        control_q[dacuc_pkg::CTL_PIN_OE];
    assign conversion_busy = (state_q == dacuc_pkg::DACUC_BUSY);

    // assertions; each label line names the rule that it guards
    sequence s_low_then_trig;
        wr_low ##1 (!wr_high)[*1];
    endsequence

    // selected flag seen low and then high
    sequence s_flag_rise;
        !sel_flag ##1 sel_flag;
    endsequence

    // auto mode edge that lands inside a conversion window
    sequence s_busy_edge;
        auto_trigger_enable && conversion_busy && trig_edge;
    endsequence

    a_write_mode_load: assert property (
        @(posedge pclk) disable iff (!presetn)
        load_write |=> shadow_value == $past(wr_value))
        else $error("high write did not load shadow");
    a_auto_trig_load: assert property (
        @(posedge pclk) disable iff (!presetn)
        (auto_trigger_enable && trig_edge && !low_pending_q && !wr_high
         && !conversion_busy) |=> shadow_value == $past(value_sel))
        else $error("trigger edge did not load shadow");
    a_low_blocks: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_low_then_trig |-> !load_trig)
        else $error("update after low write without high write");
    a_busy_ignores: assert property (
        @(posedge pclk) disable iff (!presetn)
        conversion_busy |-> !load_trig)
        else $error("trigger accepted during conversion");
    a_shadow_stable: assert property (
        @(posedge pclk) disable iff (!presetn)
        (!load_write && !load_trig) |=> $stable(shadow_value))
        else $error("shadow changed without a load");
    a_align_waits: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_ctl && !wr_high) |=> $stable(align_q))
        else $error("alignment changed without high write");
    a_no_auto_write: assert property (
        @(posedge pclk) disable iff (!presetn)
        (!auto_trigger_enable && !wr_high) |=> $stable(shadow_value))
        else $error("shadow changed outside high write in write mode");
    a_pin_route: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_ctl |=> analog_pin_output_enable == $past(pwdata[1]))
        else $error("pin routing bit not applied");
    a_enable_bit: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_ctl |=> converter_enable == $past(pwdata[0]))
        else $error("enable bit not applied");
    a_edge_found: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_flag_rise |-> trig_edge)
        else $error("flag rise not seen as an edge");
    a_edge_lost: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_busy_edge |=> $stable(shadow_value))
        else $error("edge during conversion changed the shadow");
    a_count_start: assert property (
        @(posedge pclk) disable iff (!presetn)
        (load_write || load_trig) |=> conversion_busy
        && conv_cnt_q == dacuc_pkg::CONV_CYCLES_W)
        else $error("conversion window not opened by a load");
    a_busy_done: assert property (
        @(posedge pclk) disable iff (!presetn)
        (conversion_busy && conv_cnt_q == 8'h01 && !load_write)
        |=> !conversion_busy)
        else $error("conversion window did not close");
    a_low_arms: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_low |=> low_pending_q)
        else $error("low write did not arm the block");
    a_high_releases: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_high |=> !low_pending_q)
        else $error("high write did not release the block");
    a_align_latch: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_high |=> align_q == $past(left_align))
        else $error("alignment not taken at high write");
    a_manual_no_trig: assert property (
        @(posedge pclk) disable iff (!presetn)
        !auto_trigger_enable |-> !load_trig)
        else $error("trigger load outside auto mode");
    a_left_value: assert property (
        @(posedge pclk) disable iff (!presetn)
        (load_write && left_align)
        |=> shadow_value[9:2] == $past(pwdata[7:0]))
        else $error("left adjusted value placed wrongly");
    a_right_value: assert property (
        @(posedge pclk) disable iff (!presetn)
        (load_write && !left_align)
        |=> shadow_value == {$past(pwdata[1:0]), $past(value_low_q)})
        else $error("right adjusted value placed wrongly");
endmodule : dacuc_top

/* File: sim/dacuc_top_bench.sv */
// Purpose: self-checking bench for the converter update control block
// Assumes: zero-wait apb slave, flags filtered over a few cycles
// Notes: each scenario task drives the block and judges the result
`timescale 1ns/10ps
module dacuc_top_bench;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, er;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [7:0] trigger_flags = 8'h00;
    logic [9:0] shadow_value;
    logic converter_enable, analog_pin_output_enable, conversion_busy;
    int n_mismatch = 0, num_checks = 0;

    dacuc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .trigger_flags(trigger_flags), .shadow_value(shadow_value),
        .converter_enable(converter_enable), .conversion_busy(conversion_busy),
        .analog_pin_output_enable(analog_pin_output_enable));

    // 20 MHz system clock
    always #25 pclk = ~pclk;

    task summarize;
        if (n_mismatch == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : summarize

    task chk(input string nm, input logic [31:0] got, input logic [31:0] ex);
        num_checks++;
        if (got !== ex) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk

    // one apb transfer; request held until pready is seen high
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            n_mismatch++;
            summarize();
        end
        rd = prdata; er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    // bounded wait for the conversion window to close
    task wait_idle;
        int i;
        for (i = 0; i < 60 && conversion_busy !== 1'b0; i++) @(posedge pclk);
        if (i == 60) begin
            n_mismatch++;
            summarize();
        end
    endtask : wait_idle

    // raise one flag, give the filter time, judge the shadow, drop it
    task pulse(input int k, input logic [9:0] ex);
        trigger_flags <= 8'h01 << k;
        repeat (12) @(posedge pclk);
        chk("shadow", 32'(shadow_value), 32'(ex));
        trigger_flags <= 8'h00;
        repeat (8) @(posedge pclk);
    endtask : pulse

    task t_reset;
        apb(1'b0, dacuc_pkg::OFF_CONTROL, 32'h0);
        chk("control", rd, 32'h0);
        apb(1'b0, dacuc_pkg::OFF_VALUE_LOW, 32'h0);
        chk("low", rd, 32'h0);
        apb(1'b0, dacuc_pkg::OFF_VALUE_HIGH, 32'h0);
        chk("high", rd, 32'h0);
        chk("shadow", 32'(shadow_value), 32'h0);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped err", 32'(er), 32'h1);
    endtask : t_reset

    task t_control;
        apb(1'b1, dacuc_pkg::OFF_CONTROL, 32'hff);
        apb(1'b0, dacuc_pkg::OFF_CONTROL, 32'h0);
        chk("control rb", rd, 32'hf7);
        chk("enable", 32'(converter_enable), 32'h1);
        chk("pin oe", 32'(analog_pin_output_enable), 32'h1);
        apb(1'b1, dacuc_pkg::OFF_CONTROL, 32'h0);
        // the write landed at the last edge inside apb; wait one more edge so it has settled
        @(posedge pclk);
        chk("enable", 32'(converter_enable), 32'h0);
        chk("pin oe", 32'(analog_pin_output_enable), 32'h0);
    endtask : t_control

    // write mode: low holds back, high completes, alignment waits
    task t_write_mode;
        apb(1'b1, dacuc_pkg::OFF_CONTROL, 32'h01);
        apb(1'b1, dacuc_pkg::OFF_VALUE_LOW, 32'h34);
        repeat (3) @(posedge pclk);
        chk("shadow", 32'(shadow_value), 32'h0);
        apb(1'b1, dacuc_pkg::OFF_VALUE_HIGH, 32'h02);
        repeat (2) @(posedge pclk);
        chk("shadow", 32'(shadow_value), 32'h234);
        chk("busy", 32'(conversion_busy), 32'h1);
        wait_idle();
        apb(1'b1, dacuc_pkg::OFF_CONTROL, 32'h05);
        repeat (3) @(posedge pclk);
        chk("shadow", 32'(shadow_value), 32'h234);
        apb(1'b1, dacuc_pkg::OFF_VALUE_HIGH, 32'hab);
        repeat (2) @(posedge pclk);
        chk("shadow", 32'(shadow_value), 32'h2ac);
        wait_idle();
        apb(1'b1, dacuc_pkg::OFF_VALUE_HIGH, 32'h12);
        repeat (2) @(posedge pclk);
        chk("shadow", 32'(shadow_value), 32'h048);
    endtask : t_write_mode

    // every trigger code; a foreign flag must not load
    task t_triggers;
        logic [9:0] old;
        for (int k = 0; k < 8; k++) begin
            wait_idle();
            apb(1'b1, dacuc_pkg::OFF_CONTROL, 32'h85 | (k << 4));
            // shadow left by the previous scenario or iteration
            old = (k == 0) ? 10'h048 : {8'h0f + 8'(k), 2'b00};
            apb(1'b1, dacuc_pkg::OFF_VALUE_HIGH, 32'h10 + k);
            repeat (2) @(posedge pclk);
            chk("no load", 32'(shadow_value), 32'(old));
            pulse((k + 1) % 8, old);
            pulse(k, {8'h10 + 8'(k), 2'b00});
        end
    endtask : t_triggers

    // pending low write blocks; an edge during busy is lost
    task t_block_busy;
        int i;
        wait_idle();
        apb(1'b1, dacuc_pkg::OFF_VALUE_LOW, 32'hc0);
        pulse(7, 10'h05c);
        apb(1'b1, dacuc_pkg::OFF_VALUE_HIGH, 32'h33);
        trigger_flags <= 8'h80;
        for (i = 0; i < 20 && conversion_busy !== 1'b1; i++) @(posedge pclk);
        if (i == 20) begin
            n_mismatch++;
            summarize();
        end
        chk("shadow", 32'(shadow_value), 32'h0cf);
        apb(1'b1, dacuc_pkg::OFF_VALUE_HIGH, 32'h55);
        trigger_flags <= 8'h00;
        repeat (5) @(posedge pclk);
        trigger_flags <= 8'h80;
        wait_idle();
        repeat (10) @(posedge pclk);
        chk("shadow", 32'(shadow_value), 32'h0cf);
        trigger_flags <= 8'h00;
        repeat (8) @(posedge pclk);
        pulse(7, 10'h157);
        // right alignment under auto trigger: low, then high, then an edge
        wait_idle();
        apb(1'b1, dacuc_pkg::OFF_CONTROL, 32'hf1);
        apb(1'b1, dacuc_pkg::OFF_VALUE_LOW, 32'h9a);
        apb(1'b1, dacuc_pkg::OFF_VALUE_HIGH, 32'h03);
        pulse(7, 10'h39a);
    endtask : t_block_busy

    // main sequence: reset for two cycles, then the scenarios
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_control();
        t_write_mode();
        t_triggers();
        t_block_busy();
        summarize();
    end
endmodule : dacuc_top_bench
